/* rtl/input_amp_map.vh */
// Register map and field constants of the input amplifier controls
`ifndef INPUT_AMP_MAP_VH
`define INPUT_AMP_MAP_VH
// Register indices; byte address is four times the index
`define AMP0_CTRL_IDX 6'h23
`define AMP1_CTRL_IDX 6'h24
`define AMP2_CTRL_IDX 6'h25
`define AMP3_CTRL_IDX 6'h26
`define AMP_CTRL_COUNT 4
`define AMP_CTRL_RESET 8'h40
// Field positions inside each control byte
`define MIC_SEL_BIT 7
`define SILENCE_BIT 6
`define LEVEL_MSB 5
`define LEVEL_LSB 0
`define LEVEL_MUTED 6'h00
// AXI4-Lite responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* rtl/input_amp_gain_control_regs.v */
// Input amplifier control register bank with AXI4-Lite slave
`timescale 1ns/1ns
`default_nettype none
`include "input_amp_map.vh"

module input_amp_gain_control_regs (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] awaddr,
  input wire [2:0] awprot,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire [2:0] arprot,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  output reg [3:0] mic_select_power,
  output reg [3:0] amp_silence,
  output reg [23:0] amp_level_code,
  output reg [3:0] amp_polarity_inverted
);

  // Stored control bytes, one per analog input
  reg [7:0] ctrl [0:`AMP_CTRL_COUNT-1];
  // Write channel: one address and one data beat held each
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [7:0] w_byte;
  reg w_lane0;
  // Decoded addresses, {valid, index}
  wire [2:0] wr_dec;
  wire [2:0] rd_dec;
  // Handshake strobes of the five channels
  wire aw_take;
  wire w_take;
  wire wr_fire;
  wire b_done;
  wire ar_take;
  wire r_done;
  // Next values of the front-end controls
  wire [3:0] next_mic;
  wire [3:0] next_silence;
  wire [23:0] next_level;
  wire [3:0] next_polarity;
  integer i;

  // Maps a byte address to {valid, index}; low two bits are ignored
  function [2:0] decode;
    input [7:0] addr;
    reg [5:0] off;
    begin
      off = addr[7:2] - `AMP0_CTRL_IDX;
      if (addr[7:2] >= `AMP0_CTRL_IDX && addr[7:2] <= `AMP3_CTRL_IDX)
        decode = {1'b1, off[1:0]};
      else
        decode = 3'h0;
    end
  endfunction

  // Gain code handed to the amplifier; zero while the mute bit is set
  function [5:0] effective_level;
    input [7:0] ctrl_byte;
    begin
      if (ctrl_byte[`SILENCE_BIT])
        effective_level = `LEVEL_MUTED;
      else
        effective_level = ctrl_byte[`LEVEL_MSB:`LEVEL_LSB];
    end
  endfunction

  // Address decode of the held write and of the offered read
  assign wr_dec = decode(aw_addr);
  assign rd_dec = decode(araddr);

  // Strobes; a store waits for both halves and a free response slot
  assign aw_take = awvalid && awready;
  assign w_take = wvalid && wready;
  assign wr_fire = aw_held && w_held && !bvalid;
  assign b_done = bvalid && bready;
  assign ar_take = arvalid && arready;
  assign r_done = rvalid && rready;

  // Write address channel; ready comes up one cycle after reset release
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else begin
      if (!aw_held && !bvalid)
        awready <= !aw_take;
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wr_fire)
        aw_held <= 1'b0;
      // Closed until the response is taken, so one write at a time
      if (b_done)
        awready <= 1'b1;
    end
  end

  // Write data channel; only the low byte lane carries register data
  always @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b0;
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else begin
      if (!w_held && !bvalid)
        wready <= !w_take;
      if (w_take) begin
        w_held <= 1'b1;
        w_byte <= wdata[7:0];
        w_lane0 <= wstrb[0];
      end
      if (wr_fire)
        w_held <= 1'b0;
      if (b_done)
        wready <= 1'b1;
    end
  end

  // Write response and store; an unmapped address is answered, not stored
  always @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      for (i = 0; i < `AMP_CTRL_COUNT; i = i + 1)
        ctrl[i] <= `AMP_CTRL_RESET;
    end else begin
      if (wr_fire) begin
        bvalid <= 1'b1;
        if (wr_dec[2]) begin
          bresp <= `RESP_OKAY;
          // Whole byte stored so reads give it back unchanged
          if (w_lane0)
            ctrl[wr_dec[1:0]] <= w_byte;
        end else begin
          bresp <= `RESP_SLVERR;
        end
      end
      if (b_done)
        bvalid <= 1'b0;
    end
  end

  // Read address channel; closed while an answer is waiting
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
    end else begin
      if (!rvalid)
        arready <= !ar_take;
      if (r_done)
        arready <= 1'b1;
    end
  end

  // Read answer, one cycle after the address; upper bits always zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else begin
      if (ar_take) begin
        rvalid <= 1'b1;
        if (rd_dec[2]) begin
          rdata <= {24'h000000, ctrl[rd_dec[1:0]]};
          rresp <= `RESP_OKAY;
        end else begin
          rdata <= 32'h00000000;
          rresp <= `RESP_SLVERR;
        end
      end
      if (r_done)
        rvalid <= 1'b0;
    end
  end

  // Per-channel decode of the stored byte into front-end controls
  genvar g;
  generate
    for (g = 0; g < `AMP_CTRL_COUNT; g = g + 1) begin : chan
      assign next_mic[g] = ctrl[g][`MIC_SEL_BIT];
      assign next_silence[g] = ctrl[g][`SILENCE_BIT];
      // Forced code so a stale gain never reaches a muted amp
      assign next_level[g*6+5:g*6] = effective_level(ctrl[g]);
      // Inversion only applies while the amplifier is in the path
      assign next_polarity[g] = ctrl[g][`MIC_SEL_BIT];
    end
  endgenerate

  // Controls lag the stored bytes by one clock; outputs leave from flops
  always @(posedge aclk) begin
    if (!aresetn) begin
      mic_select_power <= 4'h0;
      amp_silence <= 4'hF;
      amp_level_code <= 24'h000000;
      amp_polarity_inverted <= 4'h0;
    end else begin
      mic_select_power <= next_mic;
      amp_silence <= next_silence;
      amp_level_code <= next_level;
      amp_polarity_inverted <= next_polarity;
    end
  end

endmodule // input_amp_gain_control_regs
`default_nettype wire

/* verif/amp_chk_asserts.sv */
// Checker for the amp control bank
`timescale 1ns/1ns
`default_nettype none
module amp_chk (
  input wire aclk,
  input wire aresetn,
  input wire bvalid,
  input wire rvalid,
  input wire [31:0] rdata,
  input wire [3:0] mic_select_power,
  input wire [3:0] amp_silence,
  input wire [23:0] amp_level_code,
  input wire [3:0] amp_polarity_inverted
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Leaving reset: line use, muted
  AST_RST_MIC: assert property
    ($rose(aresetn) |-> !mic_select_power) else $error("mic at reset");
  AST_RST_MUTE: assert property
    ($rose(aresetn) |-> &amp_silence) else $error("unmuted at reset");
  AST_RST_LEVEL: assert property
    ($rose(aresetn) |-> !amp_level_code && !amp_polarity_inverted)
    else $error("level at reset");
  // Controls move only after a stored write
  AST_MIC_SRC: assert property
    ($changed(mic_select_power) |-> $past(bvalid)) else $error("mic moved");
  AST_GAIN_SRC: assert property
    ($changed(amp_level_code) |-> $past(bvalid)) else $error("gain moved");
  for (genvar i = 0; i < 4; i++) begin : g_ch
    AST_MUTE_GAIN: assert property
      (amp_silence[i] |-> !amp_level_code[6*i+:6]) else $error("muted gain");
  end
  AST_POL: assert property
    (amp_polarity_inverted == mic_select_power) else $error("polarity");
  AST_RD_PAD: assert property
    (rvalid |-> !rdata[31:8]) else $error("read pad");
  cover property (bvalid);
  cover property ($fell(amp_silence[0]));
  cover property (rvalid);
endmodule // amp_chk
bind input_amp_gain_control_regs amp_chk chk (.*);
`default_nettype wire

/* verif/tb_input_amp_gain_control_regs.sv */
// Bench for the amp control bank
`timescale 1ns/1ns
`default_nettype none
module tb_input_amp_gain_control_regs;
  logic aclk=0, aresetn=0, awvalid=0, wvalid=0, bready=0, arvalid=0, rready=0;
  logic [7:0] awaddr=8'h0, araddr=8'h0;
  logic [31:0] wdata=32'h0;
  logic [2:0] awprot=3'h0, arprot=3'h0;
  logic [3:0] wstrb=4'hF;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [23:0] amp_level_code;
  wire [3:0] mic_select_power, amp_silence, amp_polarity_inverted;
  wire [35:0] outs = {mic_select_power, amp_silence,
    amp_polarity_inverted, amp_level_code};
  logic [7:0] adr [4] = '{8'h8C, 8'h90, 8'h94, 8'h98};
  logic [7:0] val [4] = '{8'hBF, 8'h10, 8'hFF, 8'hC5};
  int errors=0, checks_done=0;
  input_amp_gain_control_regs dut (.*);
  initial forever #5 aclk = ~aclk;
  task automatic chk(input logic [35:0] g, e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Valids held until their own ready edge
  task automatic wr(input logic [7:0] a, d, input logic [1:0] r);
    @(posedge aclk);
    awaddr<=a; wdata<={24'h0, d}; awvalid<=1; wvalid<=1; bready<=1;
    do begin
      @(posedge aclk);
      if (awready) awvalid<=0;
      if (wready) wvalid<=0;
    end while (!bvalid);
    bready<=0;
    chk(bresp, r);
  endtask
  task automatic rd(input logic [7:0] a, d, input logic [1:0] r);
    @(posedge aclk);
    araddr<=a; arvalid<=1; rready<=1;
    do begin
      @(posedge aclk);
      if (arready) arvalid<=0;
    end while (!rvalid);
    rready<=0;
    chk({rresp, rdata}, {r, 24'h0, d});
  endtask
  task automatic t_reset;
    for (int i = 0; i < 4; i++) rd(adr[i], 8'h40, 2'h0);
    chk(outs, {4'h0, 4'hF, 4'h0, 24'h0});
    $display("reset values done");
  endtask
  // Full-scale and mid gains, muted and unmuted, both uses
  task automatic t_map;
    for (int i = 0; i < 4; i++) wr(adr[i], val[i], 2'h0);
    for (int i = 0; i < 4; i++) rd(adr[i], val[i], 2'h0);
    chk(outs, {4'hD, 4'hC, 4'hD, 24'h00043F});
    $display("channel map done");
  endtask
  task automatic t_bad;
    wr(8'h9C, 8'h55, 2'h2);
    rd(8'h88, 8'h00, 2'h2);
    rd(adr[0], val[0], 2'h0);
    wstrb <= 4'hE;
    wr(adr[1], 8'h77, 2'h0);
    wstrb <= 4'hF;
    rd(adr[1], val[1], 2'h0);
    $display("unmapped done");
  endtask
  // Reset pulse in mid-run brings every register back to 40h
  task automatic t_rst2;
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    t_reset;
    $display("mid-run reset done");
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn<=1;
    t_reset;
    t_map;
    t_bad;
    t_rst2;
    finish_test;
  end
  // Tests need under a hundred cycles
  initial begin
    #50000;
    errors++;
    finish_test;
  end
endmodule // tb_input_amp_gain_control_regs
`default_nettype wire
